// *** hdl/plmc_pkg.sv ***
package plmc_pkg;
  // Management register indices
  localparam logic [4:0]  PLMC_LINK_CTRL_IDX = 5'h10;
  localparam logic [4:0]  PLMC_MODE_CTRL_IDX = 5'h11;
  // Link control fields
  localparam int          LC_SPD_CTRL_LSB    = 8;
  localparam int          LC_LB_THR_LSB      = 4;
  localparam int          LC_LB_EN_BIT       = 3;
  localparam int          LC_PWR_DIS_BIT     = 2;
  localparam int          LC_LOGIC_RESET_BIT_BIT        = 0;
  localparam logic [15:0] LC_WMASK           = 16'h033D;
  localparam logic [15:0] LC_RMASK           = 16'h033D;
  localparam logic [15:0] LC_RESET           = 16'h0020;
  // Mode control/status fields
  localparam int          MC_ED_SHORT_BIT    = 15;
  localparam int          MC_FAST_TEST_BIT   = 14;
  localparam int          MC_EDPD_EN_BIT     = 13;
  localparam int          MC_EDPD_NLP_BIT    = 12;
  localparam int          MC_SPD_OPT_EN_BIT  = 7;
  localparam int          MC_NP_EN_BIT       = 6;
  localparam int          MC_MDIX_DIS_BIT    = 5;
  localparam int          MC_AUTO_NP_DIS_BIT = 4;
  localparam int          MC_ENERGY_BIT      = 1;
  localparam int          MC_SEMI_XOVER_BIT  = 0;
  localparam logic [15:0] MC_WMASK           = 16'hF0F1;
  localparam logic [15:0] MC_RMASK           = 16'hF0F3;
  localparam logic [15:0] MC_RESET           = 16'h0040;
  localparam logic        ENERGY_HW_RESET    = 1'b1;
  // Speed optimizer attempt counts per code
  localparam logic [2:0]  ATTEMPTS_CODE0     = 3'h7;
  localparam logic [2:0]  ATTEMPTS_CODE1     = 3'h5;
  localparam logic [2:0]  ATTEMPTS_CODE2     = 3'h4;
  localparam logic [2:0]  ATTEMPTS_CODE3     = 3'h3;
endpackage

// *** hdl/plmc_regs.sv ***
// Functional notes
// - Two-bit code sets attempts before speed downshift: 7, 5, 4, 3; resets 00.
// - Speed optimizer runs only while its enable bit 7 is one; resets off.
// - Two-bit idle-error link-break threshold code; resets to 10.
// - Link break on idle errors only while bit 3 is one; resets off.
// - Bit 2 one disables automatic power optimization; zero keeps it on.
// - Writing one to bit 0 issues a synchronous logic reset; registers untouched.
// - Logic-reset bit is never self-cleared; it keeps the last written value.
// - Bit 15 selects short energy detection; resets to normal.
// - Bit 14 enables 10BASE-T fast test mode; resets off.
// - Energy-detect power-down allowed only while bit 13 is one; resets off.
// - Bit 12 one keeps link pulses during power-down; zero sends none.
// - Next-page exchange allowed only while bit 6 is one; resets to one.
// - Bit 5 one disables auto crossover in favour of manual selection.
// - Bit 4 stops automatic next-page exchange; advertisement next-page bit decides.
// - Auto next-page off and advertised next-page zero sends base page only.
// - Read-only energy-present bit follows the line; hardware reset forces one.
// - Software reset clears the energy-present bit.
// - Energy present at software reset raises the energy event flag.
// - Bit 0 of mode control turns semi-crossover on; resets off.
// - Manual pair mapping per channel pair applies only while crossover disabled.
`timescale 1ns/1ps
module plmc_regs
  import plmc_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              sw_reset_i,
  input  wire logic [ADDR_W-1:0] mgmt_addr_i,
  input  wire logic              mgmt_wr_i,
  input  wire logic [15:0]       mgmt_wdata_i,
  input  wire logic              mgmt_rd_i,
  output logic      [15:0]       mgmt_rdata_o,
  output logic                   mgmt_rvalid_o,
  input  wire logic              line_energy_i,
  input  wire logic              adv_next_page_i,
  input  wire logic              mdix_sel_01_i,
  input  wire logic              mdix_sel_23_i,
  input  wire logic              auto_mdix_01_i,
  input  wire logic              auto_mdix_23_i,
  output logic      [2:0]        speed_opt_attempts_o,
  output logic                   speed_opt_enable_o,
  output logic      [1:0]        link_break_threshold_o,
  output logic                   link_break_enable_o,
  output logic                   power_opt_disable_o,
  output logic                   logic_reset_o,
  output logic                   logic_reset_bit_o,
  output logic                   energy_detect_short_mode_o,
  output logic                   tenbase_fast_test_enable_o,
  output logic                   energy_detect_powerdown_enable_o,
  output logic                   edpd_nlp_tx_o,
  output logic                   next_page_enable_o,
  output logic                   auto_xover_disable_o,
  output logic                   auto_next_page_disable_o,
  output logic                   base_page_only_o,
  output logic                   mdix_01_o,
  output logic                   mdix_23_o,
  output logic                   semi_xover_enable_o,
  output logic                   line_energy_present_o,
  output logic                   energy_event_flag_o
);

  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W must be at least 5");
  end

  typedef struct packed {
    logic [15:0] lc;
    logic [15:0] mc;
    logic        energy;
    logic        en_meta;
    logic        en_sync;
    logic        logic_reset_bit_pulse;
    logic        event_pulse;
    logic [2:0]  attempts;
    logic        base_only;
    logic        mdix01;
    logic        mdix23;
    logic [15:0] rdata;
    logic        rvalid;
  } plmc_state_s;

  plmc_state_s state_ff;
  plmc_state_s nxt_state;

  logic wr_lc;
  logic wr_mc;
  assign wr_lc = mgmt_wr_i && (mgmt_addr_i == ADDR_W'(PLMC_LINK_CTRL_IDX));
  assign wr_mc = mgmt_wr_i && (mgmt_addr_i == ADDR_W'(PLMC_MODE_CTRL_IDX));

  always_comb begin
    nxt_state = state_ff;
    nxt_state.en_meta = line_energy_i;
    nxt_state.en_sync = state_ff.en_meta;
    nxt_state.logic_reset_bit_pulse = 1'b0;
    nxt_state.event_pulse = 1'b0;
    nxt_state.rvalid = 1'b0;
    if (sw_reset_i) begin
      nxt_state.lc = LC_RESET;
      nxt_state.mc = MC_RESET;
      nxt_state.energy = 1'b0;
      nxt_state.event_pulse = state_ff.energy;
    end else begin
      nxt_state.energy = state_ff.en_sync;
      if (wr_lc) begin
        nxt_state.lc = mgmt_wdata_i & LC_WMASK;
        nxt_state.logic_reset_bit_pulse = mgmt_wdata_i[LC_LOGIC_RESET_BIT_BIT];
      end
      if (wr_mc) begin
        nxt_state.mc = mgmt_wdata_i & MC_WMASK;
      end
    end
    case (state_ff.lc[LC_SPD_CTRL_LSB +: 2])
      2'b00:   nxt_state.attempts = ATTEMPTS_CODE0;
      2'b01:   nxt_state.attempts = ATTEMPTS_CODE1;
      2'b10:   nxt_state.attempts = ATTEMPTS_CODE2;
      2'b11:   nxt_state.attempts = ATTEMPTS_CODE3;
      default: nxt_state.attempts = ATTEMPTS_CODE0;
    endcase
    nxt_state.base_only = state_ff.mc[MC_AUTO_NP_DIS_BIT] && !adv_next_page_i;
    nxt_state.mdix01 = state_ff.mc[MC_MDIX_DIS_BIT] ? mdix_sel_01_i
                                                    : auto_mdix_01_i;
    nxt_state.mdix23 = state_ff.mc[MC_MDIX_DIS_BIT] ? mdix_sel_23_i
                                                    : auto_mdix_23_i;
    if (mgmt_rd_i) begin
      nxt_state.rvalid = 1'b1;
      if (mgmt_addr_i == ADDR_W'(PLMC_LINK_CTRL_IDX)) begin
        nxt_state.rdata = state_ff.lc & LC_RMASK;
      end else if (mgmt_addr_i == ADDR_W'(PLMC_MODE_CTRL_IDX)) begin
        nxt_state.rdata = (state_ff.mc & MC_RMASK)
                        | (16'(state_ff.energy) << MC_ENERGY_BIT);
      end else begin
        nxt_state.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff             <= '0;
      state_ff.lc          <= LC_RESET;
      state_ff.mc          <= MC_RESET;
      state_ff.energy      <= ENERGY_HW_RESET;
      state_ff.en_meta     <= ENERGY_HW_RESET;
      state_ff.en_sync     <= ENERGY_HW_RESET;
      state_ff.attempts    <= ATTEMPTS_CODE0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from state
  assign mgmt_rdata_o                     = state_ff.rdata;
  assign mgmt_rvalid_o                    = state_ff.rvalid;
  assign speed_opt_attempts_o             = state_ff.attempts;
  assign speed_opt_enable_o               = state_ff.mc[MC_SPD_OPT_EN_BIT];
  assign link_break_threshold_o           = state_ff.lc[LC_LB_THR_LSB +: 2];
  assign link_break_enable_o              = state_ff.lc[LC_LB_EN_BIT];
  assign power_opt_disable_o              = state_ff.lc[LC_PWR_DIS_BIT];
  assign logic_reset_o                    = state_ff.logic_reset_bit_pulse;
  assign logic_reset_bit_o                = state_ff.lc[LC_LOGIC_RESET_BIT_BIT];
  assign energy_detect_short_mode_o       = state_ff.mc[MC_ED_SHORT_BIT];
  assign tenbase_fast_test_enable_o       = state_ff.mc[MC_FAST_TEST_BIT];
  assign energy_detect_powerdown_enable_o = state_ff.mc[MC_EDPD_EN_BIT];
  assign edpd_nlp_tx_o                    = state_ff.mc[MC_EDPD_NLP_BIT];
  assign next_page_enable_o               = state_ff.mc[MC_NP_EN_BIT];
  assign auto_xover_disable_o             = state_ff.mc[MC_MDIX_DIS_BIT];
  assign auto_next_page_disable_o         = state_ff.mc[MC_AUTO_NP_DIS_BIT];
  assign base_page_only_o                 = state_ff.base_only;
  assign mdix_01_o                        = state_ff.mdix01;
  assign mdix_23_o                        = state_ff.mdix23;
  assign semi_xover_enable_o              = state_ff.mc[MC_SEMI_XOVER_BIT];
  assign line_energy_present_o            = state_ff.energy;
  assign energy_event_flag_o              = state_ff.event_pulse;

  // Checks
  property p_logic_reset_bit_pulse;
    @(posedge clock_i) disable iff (srst_i)
      (wr_lc && !sw_reset_i && mgmt_wdata_i[LC_LOGIC_RESET_BIT_BIT]) |=> logic_reset_o && logic_reset_bit_o;
  endproperty
  a_logic_reset_bit_pulse: assert property (p_logic_reset_bit_pulse) else $error("logic reset pulse missing");

  property p_logic_reset_bit_hold;
    @(posedge clock_i) disable iff (srst_i)
      (!wr_lc && !sw_reset_i) |=> $stable(logic_reset_bit_o) && !logic_reset_o;
  endproperty
  a_logic_reset_bit_hold: assert property (p_logic_reset_bit_hold) else $error("logic reset bit changed alone");

  property p_attempts;
    @(posedge clock_i) disable iff (srst_i)
      (wr_lc && !sw_reset_i && mgmt_wdata_i[LC_SPD_CTRL_LSB +: 2] == 2'b11)
        ##1 !wr_lc && !sw_reset_i |=> speed_opt_attempts_o == 3'h3;
  endproperty
  a_attempts: assert property (p_attempts) else $error("attempt count wrong");

  property p_sw_energy;
    @(posedge clock_i) disable iff (srst_i)
      sw_reset_i |=> !line_energy_present_o && !speed_opt_enable_o && next_page_enable_o;
  endproperty
  a_sw_energy: assert property (p_sw_energy) else $error("energy not cleared");

  property p_event;
    @(posedge clock_i) disable iff (srst_i)
      ##1 energy_event_flag_o == $past(sw_reset_i && line_energy_present_o);
  endproperty
  a_event: assert property (p_event) else $error("energy event wrong");

  property p_hw_defaults;
    @(posedge clock_i) disable iff (1'b0)
      srst_i |=> line_energy_present_o && next_page_enable_o
                 && link_break_threshold_o == 2'b10 && !link_break_enable_o;
  endproperty
  a_hw_defaults: assert property (p_hw_defaults) else $error("reset values wrong");

  property p_base_page;
    @(posedge clock_i) disable iff (srst_i)
      (auto_next_page_disable_o && !adv_next_page_i) |=> base_page_only_o;
  endproperty
  a_base_page: assert property (p_base_page) else $error("base page only missing");

  property p_mdix;
    @(posedge clock_i) disable iff (srst_i)
      (!auto_xover_disable_o) |=> mdix_01_o == $past(auto_mdix_01_i)
                                   && mdix_23_o == $past(auto_mdix_23_i);
  endproperty
  a_mdix: assert property (p_mdix) else $error("manual mapping leaked");

  property p_reserved;
    @(posedge clock_i) disable iff (srst_i)
      (mgmt_rd_i && mgmt_addr_i == ADDR_W'(PLMC_LINK_CTRL_IDX))
        |=> mgmt_rvalid_o && (mgmt_rdata_o & ~LC_RMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_energy_on;
    @(posedge clock_i) disable iff (srst_i)
      (!sw_reset_i && line_energy_i) [*3] |=> line_energy_present_o;
  endproperty
  a_energy_on: assert property (p_energy_on) else $error("energy bit missing");

  property p_energy_off;
    @(posedge clock_i) disable iff (srst_i)
      (!sw_reset_i && !line_energy_i) [*3] |=> !line_energy_present_o;
  endproperty
  a_energy_off: assert property (p_energy_off) else $error("energy bit stuck");

  property p_read_energy;
    @(posedge clock_i) disable iff (srst_i)
      (mgmt_rd_i && mgmt_addr_i == ADDR_W'(PLMC_MODE_CTRL_IDX))
        |=> mgmt_rvalid_o && mgmt_rdata_o[MC_ENERGY_BIT] == $past(line_energy_present_o);
  endproperty
  a_read_energy: assert property (p_read_energy) else $error("energy read wrong");

  property p_read_other;
    @(posedge clock_i) disable iff (srst_i)
      (mgmt_rd_i && mgmt_addr_i != ADDR_W'(PLMC_LINK_CTRL_IDX)
                 && mgmt_addr_i != ADDR_W'(PLMC_MODE_CTRL_IDX))
        |=> mgmt_rvalid_o && mgmt_rdata_o == 16'h0000;
  endproperty
  a_read_other: assert property (p_read_other) else $error("stray read nonzero");

  property p_write_other;
    @(posedge clock_i) disable iff (srst_i)
      (mgmt_wr_i && !wr_lc && !wr_mc && !sw_reset_i)
        |=> $stable(state_ff.lc) && $stable(state_ff.mc);
  endproperty
  a_write_other: assert property (p_write_other) else $error("stray write landed");

  property p_lc_write;
    @(posedge clock_i) disable iff (srst_i)
      (wr_lc && !sw_reset_i)
        |=> {link_break_threshold_o, link_break_enable_o, power_opt_disable_o,
             logic_reset_bit_o}
            == $past({mgmt_wdata_i[LC_LB_THR_LSB +: 2], mgmt_wdata_i[LC_LB_EN_BIT],
                      mgmt_wdata_i[LC_PWR_DIS_BIT], mgmt_wdata_i[LC_LOGIC_RESET_BIT_BIT]});
  endproperty
  a_lc_write: assert property (p_lc_write) else $error("link write lost");

  property p_mc_write;
    @(posedge clock_i) disable iff (srst_i)
      (wr_mc && !sw_reset_i)
        |=> {energy_detect_short_mode_o, tenbase_fast_test_enable_o,
             energy_detect_powerdown_enable_o, edpd_nlp_tx_o, speed_opt_enable_o,
             next_page_enable_o, auto_xover_disable_o, auto_next_page_disable_o,
             semi_xover_enable_o}
            == $past({mgmt_wdata_i[MC_EDPD_NLP_BIT +: 4],
                      mgmt_wdata_i[MC_AUTO_NP_DIS_BIT +: 4],
                      mgmt_wdata_i[MC_SEMI_XOVER_BIT]});
  endproperty
  a_mc_write: assert property (p_mc_write) else $error("mode write lost");

  property p_mdix_manual;
    @(posedge clock_i) disable iff (srst_i)
      auto_xover_disable_o |=> mdix_01_o == $past(mdix_sel_01_i)
                               && mdix_23_o == $past(mdix_sel_23_i);
  endproperty
  a_mdix_manual: assert property (p_mdix_manual) else $error("manual map ignored");

  property p_base_off;
    @(posedge clock_i) disable iff (srst_i)
      (!auto_next_page_disable_o || adv_next_page_i) |=> !base_page_only_o;
  endproperty
  a_base_off: assert property (p_base_off) else $error("base page only wrongly set");

  c_logic_reset_bit:  cover property (@(posedge clock_i) disable iff (srst_i) logic_reset_o);
  c_event: cover property (@(posedge clock_i) disable iff (srst_i) energy_event_flag_o);
  c_read:  cover property (@(posedge clock_i) disable iff (srst_i)
                           mgmt_rvalid_o && mgmt_rdata_o[MC_ENERGY_BIT]);
  c_base:  cover property (@(posedge clock_i) disable iff (srst_i) base_page_only_o);
  c_mdix:  cover property (@(posedge clock_i) disable iff (srst_i)
                           auto_xover_disable_o && mdix_01_o);

endmodule

// *** testbench/plmc_smc.sv ***
`timescale 1ns/1ps
module plmc_smc (
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        event_i,
  output logic      [4:0]  addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] wdata_o
);
  int ev_owed = 0;
  int ev_cleared = 0;
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // Event flags owed a write-one clear
  always @(negedge clock_i) if (event_i === 1'b1) ev_owed <= ev_owed + 1;
  // Marks every owed event flag as cleared; issues no write
  task automatic clear_event;
    ev_cleared = ev_owed;
  endtask
  // One strobe cycle, answer sampled one cycle later
  task automatic xfer(input logic [4:0] a, input logic w, input logic [15:0] d,
                      output logic [15:0] q, output bit ok);
    @(negedge clock_i);
    addr_o = a;
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(negedge clock_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d;
    ok = w || (rvalid_i === 1'b1);
    q = rdata_i;
  endtask
endmodule

// *** testbench/tb_plmc_regs.sv ***
`timescale 1ns/1ps
module tb_plmc_regs;
  import plmc_pkg::*;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        sw_reset_i = 1'b0;
  logic        line_energy_i = 1'b1;
  logic        adv_next_page_i = 1'b0, mdix_sel_01_i = 1'b0, mdix_sel_23_i = 1'b0;
  logic        auto_mdix_01_i = 1'b0, auto_mdix_23_i = 1'b0;
  logic [4:0]  mgmt_addr_i;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o;
  logic        mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o;
  logic [2:0]  speed_opt_attempts_o;
  logic [1:0]  link_break_threshold_o;
  logic        speed_opt_enable_o, link_break_enable_o, power_opt_disable_o, logic_reset_o;
  logic        logic_reset_bit_o, energy_detect_short_mode_o, tenbase_fast_test_enable_o;
  logic        energy_detect_powerdown_enable_o, edpd_nlp_tx_o, next_page_enable_o;
  logic        auto_xover_disable_o, auto_next_page_disable_o, base_page_only_o, mdix_01_o;
  logic        mdix_23_o, semi_xover_enable_o, line_energy_present_o, energy_event_flag_o;
  int          seed = 50041;
  int          errors = 0;
  int          check_count = 0;
  logic [15:0] m16, m17, q;
  logic [15:0] exp_q [$];
  logic        en;
  bit          ok;
  logic [2:0]  att [4] = '{3'h7, 3'h5, 3'h4, 3'h3};
  wire  [15:0] lc_o = {10'h000, link_break_threshold_o, link_break_enable_o,
                       power_opt_disable_o, 1'b0, logic_reset_bit_o};
  wire  [15:0] mc_o = {energy_detect_short_mode_o, tenbase_fast_test_enable_o,
                       energy_detect_powerdown_enable_o, edpd_nlp_tx_o, 4'h0, speed_opt_enable_o,
                       next_page_enable_o, auto_xover_disable_o, auto_next_page_disable_o, 3'h0,
                       semi_xover_enable_o};
  plmc_regs i_plmc_regs (.clock_i, .srst_i, .sw_reset_i, .mgmt_addr_i, .mgmt_wr_i,
    .mgmt_wdata_i, .mgmt_rd_i, .mgmt_rdata_o, .mgmt_rvalid_o, .line_energy_i, .adv_next_page_i,
    .mdix_sel_01_i, .mdix_sel_23_i, .auto_mdix_01_i, .auto_mdix_23_i, .speed_opt_attempts_o,
    .speed_opt_enable_o, .link_break_threshold_o, .link_break_enable_o, .power_opt_disable_o,
    .logic_reset_o, .logic_reset_bit_o, .energy_detect_short_mode_o, .tenbase_fast_test_enable_o,
    .energy_detect_powerdown_enable_o, .edpd_nlp_tx_o, .next_page_enable_o,
    .auto_xover_disable_o, .auto_next_page_disable_o, .base_page_only_o, .mdix_01_o, .mdix_23_o,
    .semi_xover_enable_o, .line_energy_present_o, .energy_event_flag_o);
  plmc_smc i_plmc_smc (.clock_i(clock_i), .rdata_i(mgmt_rdata_o), .rvalid_i(mgmt_rvalid_o),
    .event_i(energy_event_flag_o), .addr_o(mgmt_addr_i), .wr_o(mgmt_wr_i), .rd_o(mgmt_rd_i),
    .wdata_o(mgmt_wdata_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_plmc_smc.xfer(a, 1'b1, d, q, ok);
    if (a == PLMC_LINK_CTRL_IDX) m16 = d & 16'h033D;
    if (a == PLMC_MODE_CTRL_IDX) m17 = d & 16'hF0F1;
  endtask
  task automatic rd(input logic [4:0] a);
    exp_q.push_back(a == 5'h10 ? m16 : a == 5'h11 ? (m17 | {14'h0000, en, 1'b0}) : 16'h0000);
    i_plmc_smc.xfer(a, 1'b0, 16'h0000, q, ok);
    check({15'h0000, ok}, 16'h0001);
    check(q, exp_q.pop_front());
  endtask
  task automatic soft_reset(input logic was_on);
    sw_reset_i = 1'b1;
    @(negedge clock_i);
    sw_reset_i = 1'b0;
    check({15'h0000, energy_event_flag_o}, {15'h0000, was_on});
    check({15'h0000, line_energy_present_o}, 16'h0000);
    m16 = 16'h0020;
    m17 = 16'h0040;
  endtask
  initial begin
    m16 = 16'h0020;
    m17 = 16'h0040;
    en = 1'b1;
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    check(lc_o, 16'h0020);
    check(mc_o, 16'h0040);
    check({13'h0000, speed_opt_attempts_o}, 16'h0007);
    check({15'h0000, line_energy_present_o}, 16'h0001);
    rd(5'h10);
    rd(5'h11);
    for (int c = 0; c < 4; c++) begin
      wr(PLMC_LINK_CTRL_IDX, 16'(c << 8));
      @(negedge clock_i);
      check({13'h0000, speed_opt_attempts_o}, {13'h0000, att[c]});
    end
    for (int n = 0; n < 40; n++) begin
      {adv_next_page_i, mdix_sel_01_i, mdix_sel_23_i, auto_mdix_01_i, auto_mdix_23_i} =
        5'($random(seed));
      wr(PLMC_LINK_CTRL_IDX, 16'($random(seed)));
      check({15'h0000, logic_reset_o}, {15'h0000, m16[0]});
      wr(PLMC_MODE_CTRL_IDX, 16'($random(seed)));
      check({15'h0000, logic_reset_o}, 16'h0000);
      check(lc_o, m16 & 16'h003D);
      check(mc_o, m17);
      @(negedge clock_i);
      check({13'h0000, base_page_only_o, mdix_01_o, mdix_23_o}, {13'h0000,
        m17[4] & !adv_next_page_i, m17[5] ? mdix_sel_01_i : auto_mdix_01_i,
        m17[5] ? mdix_sel_23_i : auto_mdix_23_i});
      wr(5'($random(seed)), 16'($random(seed)));
      rd(5'($random(seed)));
      rd(PLMC_LINK_CTRL_IDX);
      rd(PLMC_MODE_CTRL_IDX);
    end
    soft_reset(1'b1);
    check(mc_o, 16'h0040);
    line_energy_i = 1'b0;
    repeat (5) @(negedge clock_i);
    en = 1'b0;
    check({15'h0000, line_energy_present_o}, 16'h0000);
    check(16'(i_plmc_smc.ev_owed - i_plmc_smc.ev_cleared), 16'h0001);
    i_plmc_smc.clear_event();
    rd(5'h11);
    soft_reset(1'b0);
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check({15'h0000, line_energy_present_o}, 16'h0001);
    srst_i = 1'b0;
    line_energy_i = 1'b1;
    repeat (5) @(negedge clock_i);
    en = 1'b1;
    rd(5'h11);
    check(16'(i_plmc_smc.ev_owed - i_plmc_smc.ev_cleared), 16'h0000);
    print_verdict();
  end
endmodule
